// *** common/csoir_pkg.sv ***
// csoir package: register map, field positions and reset values of the core register group
`default_nettype none
package csoir_pkg;
    // ==========================================================
    // register offsets (byte addresses on the plain port)
    localparam logic [8:0] CSOIR_STATUS_OFF = 9'h003;
    localparam logic [8:0] CSOIR_INTCTL_OFF = 9'h00b;
    localparam logic [8:0] CSOIR_OPTION_OFF = 9'h081;
    localparam logic [8:0] CSOIR_PMASK_OFF = 9'h08c;
    localparam logic [8:0] CSOIR_PFLAG_OFF = 9'h00c;
    localparam logic [8:0] CSOIR_PORT_B_PINS_OFF = 9'h006;
    // ==========================================================
    // status field positions
    localparam int CSOIR_ST_IRP = 7;
    localparam int CSOIR_ST_RP_LO = 5;
    localparam int CSOIR_ST_TO = 4;
    localparam int CSOIR_ST_PD = 3;
    localparam int CSOIR_ST_Z = 2;
    localparam int CSOIR_ST_DC = 1;
    localparam int CSOIR_ST_C = 0;
    // option field positions
    localparam int CSOIR_OP_PU = 7;
    localparam int CSOIR_OP_EDGE = 6;
    localparam int CSOIR_OP_SRC = 5;
    localparam int CSOIR_OP_TEDGE = 4;
    localparam int CSOIR_OP_PSA = 3;
    // interrupt control field positions
    localparam int CSOIR_IC_GIE = 7;
    localparam int CSOIR_IC_PERIPH_IRQ_GATE = 6;
    localparam int CSOIR_IC_T0E = 5;
    localparam int CSOIR_IC_EXT_PIN_IRQ_EN = 4;
    localparam int CSOIR_IC_RBE = 3;
    localparam int CSOIR_IC_T0F = 2;
    localparam int CSOIR_IC_EXT_PIN_FLAG = 1;
    localparam int CSOIR_IC_RBF = 0;
    // ==========================================================
    // reset values
    localparam logic [7:0] CSOIR_STATUS_RST = 8'h18;
    localparam logic [7:0] CSOIR_OPTION_RST = 8'hff;
    localparam logic [7:0] CSOIR_INTCTL_RST = 8'h00;
    localparam logic [7:0] CSOIR_PMASK_RST = 8'h00;
    // ==========================================================
    // alu operation class reported by the datapath
    typedef enum logic [2:0] {
        CSOIR_ALU_NONE = 3'b001,
        CSOIR_ALU_ARITH = 3'b010,
        CSOIR_ALU_ROT = 3'b100
    } csoir_alu_t;
endpackage
`default_nettype wire

// *** design/csoir_regs.sv ***
// csoir_regs: core status, option and interrupt control register group
//
// Added by the designer: the plain strobed port.
`default_nettype none

// Notes on behaviour
// - flag-updating write to status keeps alu flags
// - software cannot write timeout and sleep bits
// - clear of status gives 000u uluu
// - bit 7 picks indirect banks two/three
// - bits 6-5 pick direct 128-byte bank
// - timeout bit set by kick/sleep, cleared by expiry
// - sleep bit set by kick, cleared by sleep
// - zero flag follows result equal zero
// - digit carry from low nibble carry
// - carry from msb; rotates load shifted bit
// - option bit 7 disables all pull-ups
// - option bit 6 selects pin edge
// - option bits 5-4 timer source and edge
// - option bit 3 assigns shared prescaler
// - rate bits give doubling prescale ratios
// - flags set regardless of enables
// - global enable gates every interrupt
// - peripheral gate enables peripheral interrupts
// - timer overflow flag sticks until cleared
// - selected pin edge sets sticky flag
// - upper port mismatch keeps setting change flag
// - mask holds one enable per peripheral
// - peripheral flags register holds source flags
module csoir_regs
    import csoir_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic clk_en,
    // plain register port
    input wire logic [8:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // datapath side
    input wire logic status_dest_flags, // write targets status and op updates flags
    input wire logic clr_status, // clear-register instruction on status
    input wire csoir_alu_t alu_op,
    input wire logic [7:0] alu_res,
    input wire logic alu_c,
    input wire logic alu_dc,
    input wire logic watchdog_kick_instr,
    input wire logic sleep_instr,
    input wire logic watchdog_timeout,
    // peripheral side
    input wire logic tmr_a_ovf,
    input wire logic [7:0] periph_set,
    input wire logic ext_irq_pin,
    input wire logic [7:0] port_b_pins,
    // configuration outputs
    output logic indirect_bank_hi,
    output logic [1:0] direct_bank_sel,
    output logic pullup_disable,
    output logic pin_edge_sel,
    output logic tmr_a_src_sel,
    output logic tmr_a_edge_sel,
    output logic prescaler_owner_sel,
    output logic [2:0] prescale_rate,
    output logic [8:0] tmr_a_ratio, // divide ratio for the timer
    output logic [7:0] wdt_ratio, // divide ratio for the watchdog
    output logic irq_req
);
    // ==========================================================
    // state
    logic [7:0] status_reg, status_next; // cpu_status
    logic [7:0] option_reg; // timer_option_config
    logic [7:0] intctl_reg, intctl_next; // interrupt_control
    logic [7:0] pmask_reg; // peripheral_irq_mask
    logic [7:0] pflag_reg, pflag_next; // periph_flag_reg
    logic [1:0] pin_sync_reg; // two-stage synchroniser for the pin
    logic pin_prev_reg;
    logic [7:0] pb_s1_reg, pb_s2_reg; // port synchroniser
    logic [3:0] pb_latch_reg; // last value read from upper nibble
    logic [7:0] rdata_reg;
    logic irq_reg;
    logic [7:0] opt_out_reg;
    logic [2:0] bank_out_reg;
    logic [8:0] tr_reg;
    logic [7:0] wr_reg;

    // ==========================================================
    // decode
    wire wr_status = wr && addr == CSOIR_STATUS_OFF;
    wire wr_intctl = wr && addr == CSOIR_INTCTL_OFF;
    wire wr_option = wr && addr == CSOIR_OPTION_OFF;
    wire wr_pmask = wr && addr == CSOIR_PMASK_OFF;
    wire wr_pflag = wr && addr == CSOIR_PFLAG_OFF;
    wire rd_port_b_pins = rd && addr == CSOIR_PORT_B_PINS_OFF;
    wire flags_upd = alu_op != CSOIR_ALU_NONE;
    wire pin_s = pin_sync_reg[1];
    // rising when edge bit is 1, falling otherwise
    wire pin_edge = option_reg[CSOIR_OP_EDGE] ? (pin_s && !pin_prev_reg)
                                              : (!pin_s && pin_prev_reg);
    wire pb_mismatch = pb_s2_reg[7:4] != pb_latch_reg;

    // ==========================================================
    // status next value
    always_comb begin
        status_next = status_reg;
        // software write, only the bank bits, plus the flags when status_dest_flags is low
        if (wr_status && clk_en) begin
            status_next[7:5] = wdata[7:5];
            if (!status_dest_flags) begin
                status_next[2:0] = wdata[2:0];
            end
            // timeout and sleep bits never taken from data
        end
        if (clr_status) begin
            status_next[7:5] = 3'b000;
        end
        // alu flags override the data write
        if (flags_upd) begin
            status_next[CSOIR_ST_Z] = alu_res == 8'h00;
            if (alu_op == CSOIR_ALU_ARITH) begin
                status_next[CSOIR_ST_DC] = alu_dc;
                status_next[CSOIR_ST_C] = alu_c;
            end else begin
                status_next[CSOIR_ST_C] = alu_c; // rotate shifted-out bit
            end
        end
        if (clr_status) begin
            status_next[CSOIR_ST_Z] = 1'b1;
        end
        // hardware events; expiry has priority over kick
        if (watchdog_kick_instr) begin
            status_next[CSOIR_ST_TO] = 1'b1;
            status_next[CSOIR_ST_PD] = 1'b1;
        end
        if (sleep_instr) begin
            status_next[CSOIR_ST_TO] = 1'b1;
            status_next[CSOIR_ST_PD] = 1'b0;
        end
        if (watchdog_timeout) begin
            status_next[CSOIR_ST_TO] = 1'b0;
        end
    end

    // ==========================================================
    // interrupt control and peripheral flags; set wins over clear
    always_comb begin
        intctl_next = intctl_reg;
        if (wr_intctl) begin
            intctl_next = wdata;
        end
        // flags set whatever the enables
        if (tmr_a_ovf) begin
            intctl_next[CSOIR_IC_T0F] = 1'b1;
        end
        if (pin_edge) begin
            intctl_next[CSOIR_IC_EXT_PIN_FLAG] = 1'b1;
        end
        if (pb_mismatch) begin
            intctl_next[CSOIR_IC_RBF] = 1'b1;
        end
        pflag_next = wr_pflag ? wdata : pflag_reg;
        pflag_next = pflag_next | periph_set;
    end

    // ==========================================================
    // request combine
    wire core_hit = |(intctl_reg[5:3] & intctl_reg[2:0]);
    wire per_hit = intctl_reg[CSOIR_IC_PERIPH_IRQ_GATE] && |(pflag_reg & pmask_reg);
    wire irq_next = intctl_reg[CSOIR_IC_GIE] && (core_hit || per_hit);

    // ==========================================================
    // read mux; unmapped addresses read zero
    logic [7:0] rd_mux;
    always_comb begin
        unique case (addr)
            CSOIR_STATUS_OFF: rd_mux = status_reg;
            CSOIR_INTCTL_OFF: rd_mux = intctl_reg;
            CSOIR_OPTION_OFF: rd_mux = option_reg;
            CSOIR_PMASK_OFF: rd_mux = pmask_reg;
            CSOIR_PFLAG_OFF: rd_mux = pflag_reg;
            CSOIR_PORT_B_PINS_OFF: rd_mux = pb_s2_reg;
            default: rd_mux = 8'h00;
        endcase
    end

    // ratio decode
    function automatic logic [8:0] csoir_pow2(input logic [2:0] code, input logic base);
        // four-bit sum: code 7 plus base 1 must reach a shift of 8, not wrap to 0
        csoir_pow2 = 9'h001 << ({1'b0, code} + {3'b000, base});
    endfunction
    // prescaler goes to timer only when owner bit is 0
    wire [8:0] tr_next = option_reg[CSOIR_OP_PSA] ? 9'h001 : csoir_pow2(option_reg[2:0], 1'b1);
    wire [8:0] wr_full = option_reg[CSOIR_OP_PSA] ? csoir_pow2(option_reg[2:0], 1'b0) : 9'h001;

    // ==========================================================
    // registers
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            status_reg <= CSOIR_STATUS_RST;
            option_reg <= CSOIR_OPTION_RST;
            intctl_reg <= CSOIR_INTCTL_RST;
            pmask_reg <= CSOIR_PMASK_RST;
            pflag_reg <= 8'h00;
            pin_sync_reg <= 2'b00;
            pin_prev_reg <= 1'b0;
            pb_s1_reg <= 8'h00;
            pb_s2_reg <= 8'h00;
            pb_latch_reg <= 4'h0;
            rdata_reg <= 8'h00;
            irq_reg <= 1'b0;
            opt_out_reg <= CSOIR_OPTION_RST;
            bank_out_reg <= 3'b000;
            tr_reg <= 9'h001;
            wr_reg <= 8'h01;
        end else if (clk_en) begin
            status_reg <= status_next;
            intctl_reg <= intctl_next;
            pflag_reg <= pflag_next;
            if (wr_option) begin
                option_reg <= wdata;
            end
            if (wr_pmask) begin
                pmask_reg <= wdata;
            end
            pin_sync_reg <= {pin_sync_reg[0], ext_irq_pin};
            pin_prev_reg <= pin_s;
            pb_s1_reg <= port_b_pins;
            pb_s2_reg <= pb_s1_reg;
            if (rd_port_b_pins) begin
                pb_latch_reg <= pb_s2_reg[7:4]; // read ends the mismatch
            end
            rdata_reg <= rd ? rd_mux : 8'h00;
            irq_reg <= irq_next;
            opt_out_reg <= option_reg;
            bank_out_reg <= status_reg[7:5];
            tr_reg <= tr_next;
            wr_reg <= wr_full[7:0];
        end
    end

    // ==========================================================
    // outputs straight from flip-flops
    assign rdata = rdata_reg;
    assign irq_req = irq_reg;
    assign indirect_bank_hi = bank_out_reg[2];
    assign direct_bank_sel = bank_out_reg[1:0];
    assign pullup_disable = opt_out_reg[CSOIR_OP_PU];
    assign pin_edge_sel = opt_out_reg[CSOIR_OP_EDGE];
    assign tmr_a_src_sel = opt_out_reg[CSOIR_OP_SRC];
    assign tmr_a_edge_sel = opt_out_reg[CSOIR_OP_TEDGE];
    assign prescaler_owner_sel = opt_out_reg[CSOIR_OP_PSA];
    assign prescale_rate = opt_out_reg[2:0];
    assign tmr_a_ratio = tr_reg;
    assign wdt_ratio = wr_reg;

    // ==========================================================
    // checks
    sequence kick_s;
        clk_en && watchdog_kick_instr && !sleep_instr && !watchdog_timeout;
    endsequence
    sleep_bit_a: assert property (@(posedge clock) disable iff (rst)
        clk_en && sleep_instr |=> !status_reg[CSOIR_ST_PD])
        else $error("sleep bit not cleared");
    kick_bits_a: assert property (@(posedge clock) disable iff (rst)
        kick_s |=> status_reg[CSOIR_ST_TO] && status_reg[CSOIR_ST_PD])
        else $error("kick did not set status bits");
    expiry_bit_a: assert property (@(posedge clock) disable iff (rst)
        clk_en && watchdog_timeout |=> !status_reg[CSOIR_ST_TO])
        else $error("expiry not recorded");
    sw_protect_a: assert property (@(posedge clock) disable iff (rst)
        clk_en && !watchdog_kick_instr && !sleep_instr && !watchdog_timeout
        |=> $stable(status_reg[4:3]))
        else $error("protected bits changed");
    clr_pattern_a: assert property (@(posedge clock) disable iff (rst)
        clk_en && clr_status |=> status_reg[7:5] == 3'b000 && status_reg[CSOIR_ST_Z])
        else $error("clear pattern wrong");
    zero_flag_a: assert property (@(posedge clock) disable iff (rst)
        clk_en && flags_upd && !clr_status |=> status_reg[CSOIR_ST_Z] == ($past(alu_res) == 8'h00))
        else $error("zero flag wrong");
    flag_block_a: assert property (@(posedge clock) disable iff (rst)
        clk_en && wr_status && status_dest_flags && alu_op == CSOIR_ALU_ARITH && !clr_status
        |=> status_reg[CSOIR_ST_DC] == $past(alu_dc) && status_reg[CSOIR_ST_C] == $past(alu_c))
        else $error("data write reached alu flags");
    tmr_flag_a: assert property (@(posedge clock) disable iff (rst)
        clk_en && tmr_a_ovf |=> intctl_reg[CSOIR_IC_T0F])
        else $error("overflow flag lost");
    gie_gate_a: assert property (@(posedge clock) disable iff (rst)
        clk_en && !intctl_reg[CSOIR_IC_GIE] |=> !irq_req)
        else $error("request without global enable");
    per_gate_a: assert property (@(posedge clock) disable iff (rst)
        clk_en && !intctl_reg[CSOIR_IC_PERIPH_IRQ_GATE] && !core_hit |=> !irq_req)
        else $error("peripheral passed closed gate");

    // ==========================================================
    // checks on flags, output copies, the request and the freeze
    // plain copies so that $past sees a whole signal
    wire [2:0] bank_bits = status_reg[7:5];
    wire [3:0] pb_upper = pb_s2_reg[7:4];
    // a rotate that targets status must leave the digit carry alone
    dc_block_a: assert property (@(posedge clock) disable iff (rst)
        clk_en && wr_status && status_dest_flags && alu_op == CSOIR_ALU_ROT && !clr_status
        |=> $stable(status_reg[CSOIR_ST_DC]))
        else $error("data write reached digit carry");
    // each pin edge of the chosen polarity must land in the flag
    pin_flag_a: assert property (@(posedge clock) disable iff (rst)
        clk_en && pin_edge |=> intctl_reg[CSOIR_IC_EXT_PIN_FLAG])
        else $error("pin edge flag lost");
    // a standing mismatch keeps the change flag set, even over a clear
    port_flag_a: assert property (@(posedge clock) disable iff (rst)
        clk_en && pb_mismatch |=> intctl_reg[CSOIR_IC_RBF])
        else $error("port change flag lost");
    // a port read copies the synced upper nibble into the latch
    sequence port_read_s;
        clk_en && rd_port_b_pins;
    endsequence
    port_latch_a: assert property (@(posedge clock) disable iff (rst)
        port_read_s |=> pb_latch_reg == $past(pb_upper))
        else $error("port latch not updated");
    // peripheral set pulses are never dropped by a same-cycle write
    pflag_set_a: assert property (@(posedge clock) disable iff (rst)
        clk_en && periph_set != 8'h00 |=> (pflag_reg & $past(periph_set)) == $past(periph_set))
        else $error("peripheral flag lost");
    // enabled core flag under the global enable raises the request
    irq_core_a: assert property (@(posedge clock) disable iff (rst)
        clk_en && intctl_reg[CSOIR_IC_GIE] && core_hit |=> irq_req)
        else $error("core request missing");
    // masked peripheral flag through an open gate raises it too
    irq_per_a: assert property (@(posedge clock) disable iff (rst)
        clk_en && intctl_reg[CSOIR_IC_GIE] && per_hit |=> irq_req)
        else $error("peripheral request missing");
    // output copies trail their registers by exactly one enabled edge
    bank_out_a: assert property (@(posedge clock) disable iff (rst)
        clk_en |=> {indirect_bank_hi, direct_bank_sel} == $past(bank_bits))
        else $error("bank outputs stale");
    opt_out_a: assert property (@(posedge clock) disable iff (rst)
        clk_en |=> {pullup_disable, pin_edge_sel, tmr_a_src_sel, tmr_a_edge_sel,
            prescaler_owner_sel, prescale_rate} == $past(option_reg))
        else $error("option outputs stale");
    // ratios agree with the owner and rate outputs beside them
    ratio_out_a: assert property (@(posedge clock) disable iff (rst)
        clk_en |=> tmr_a_ratio == (prescaler_owner_sel ? 9'h001 : 9'h002 << prescale_rate)
            && wdt_ratio == (prescaler_owner_sel ? 8'h01 << prescale_rate : 8'h01))
        else $error("prescale ratio wrong");
    // read data stands one cycle after the strobe and is zero otherwise
    rdata_a: assert property (@(posedge clock) disable iff (rst)
        clk_en |=> rdata == ($past(rd) ? $past(rd_mux) : 8'h00))
        else $error("read data wrong");
    // low enable freezes every register of the group
    freeze_hold_a: assert property (@(posedge clock) disable iff (rst)
        !clk_en |=> $stable(status_reg) && $stable(intctl_reg) && $stable(option_reg)
            && $stable(pflag_reg) && $stable(pmask_reg) && $stable(irq_req))
        else $error("state moved while frozen");
endmodule
`default_nettype wire

// *** bench/csoir_regs_tb_top.sv ***
// csoir_regs_tb_top: self-checking bench for the core register group
`default_nettype none
module csoir_regs_tb_top;
    import csoir_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // stimulus and observed signals
    logic clock = 1'b0, rst = 1'b1, clk_en = 1'b1; // clk_en dropped once near the end
    logic [8:0] addr = '0;
    logic [7:0] wdata = '0, alu_res = '0, periph_set = '0, port_b_pins = '0, rdata;
    logic wr = 1'b0, rd = 1'b0, status_dest_flags = 1'b0, clr_status = 1'b0;
    logic alu_c = 1'b0, alu_dc = 1'b0, watchdog_kick_instr = 1'b0, sleep_instr = 1'b0;
    logic watchdog_timeout = 1'b0, tmr_a_ovf = 1'b0, ext_irq_pin = 1'b0;
    csoir_alu_t alu_op = CSOIR_ALU_NONE;
    logic indirect_bank_hi, pullup_disable, pin_edge_sel, tmr_a_src_sel, tmr_a_edge_sel;
    logic prescaler_owner_sel, irq_req;
    logic [1:0] direct_bank_sel;
    logic [2:0] prescale_rate;
    logic [8:0] tmr_a_ratio;
    logic [7:0] wdt_ratio, v;
    int n_fail = 0, num_checks = 0;
    // ==========================================================
    // device under test
    csoir_regs csoir_regs_i (.clock(clock), .rst(rst), .clk_en(clk_en), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .status_dest_flags(status_dest_flags),
        .clr_status(clr_status), .alu_op(alu_op), .alu_res(alu_res), .alu_c(alu_c),
        .alu_dc(alu_dc), .watchdog_kick_instr(watchdog_kick_instr), .sleep_instr(sleep_instr),
        .watchdog_timeout(watchdog_timeout), .tmr_a_ovf(tmr_a_ovf), .periph_set(periph_set),
        .ext_irq_pin(ext_irq_pin), .port_b_pins(port_b_pins),
        .indirect_bank_hi(indirect_bank_hi), .direct_bank_sel(direct_bank_sel),
        .pullup_disable(pullup_disable), .pin_edge_sel(pin_edge_sel),
        .tmr_a_src_sel(tmr_a_src_sel), .tmr_a_edge_sel(tmr_a_edge_sel),
        .prescaler_owner_sel(prescaler_owner_sel), .prescale_rate(prescale_rate),
        .tmr_a_ratio(tmr_a_ratio), .wdt_ratio(wdt_ratio), .irq_req(irq_req));
    // ==========================================================
    // clock, 100 MHz
    initial begin
        forever #5 clock = ~clock;
    end
    // ==========================================================
    // helper tasks
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // compare and count; x never matches
    task automatic chk(string nm, logic [8:0] exp, logic [8:0] got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one-cycle write strobe
    task automatic wr_reg(logic [8:0] a, logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask
    // one-cycle read strobe, data checked in the following cycle only
    task automatic rd_reg(logic [8:0] a, logic [7:0] m, logic [7:0] e, string nm);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        @(negedge clock);
        chk(nm, {1'b0, e & m}, {1'b0, rdata & m});
    endtask
    // single-cycle event pulses: 0 expiry, 1 sleep, 2 kick, 3 timer overflow, 4 clear
    task automatic ev(int k);
        @(posedge clock);
        case (k)
            0: watchdog_timeout <= 1'b1;
            1: sleep_instr <= 1'b1;
            2: watchdog_kick_instr <= 1'b1;
            3: tmr_a_ovf <= 1'b1;
            default: clr_status <= 1'b1;
        endcase
        @(posedge clock);
        {watchdog_timeout, sleep_instr, watchdog_kick_instr, tmr_a_ovf, clr_status} <= 5'b0;
    endtask
    // alu result, optionally paired with a flag-updating write to the status register
    task automatic alu(csoir_alu_t op, logic [7:0] r, logic c, logic dc, logic dst);
        @(posedge clock);
        alu_op <= op;
        {alu_res, alu_c, alu_dc} <= {r, c, dc};
        addr <= CSOIR_STATUS_OFF;
        wdata <= 8'h20;
        {wr, status_dest_flags} <= {dst, dst};
        @(posedge clock);
        {wr, status_dest_flags} <= 2'b00;
        alu_op <= CSOIR_ALU_NONE;
    endtask
    // ==========================================================
    // watchdog: the sequence needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clock);
        n_fail++;
        $display("MISMATCH watchdog expected done seen hang");
        print_verdict();
    end
    // ==========================================================
    // main sequence
    initial begin
        repeat (11) @(posedge clock);
        @(negedge clock);
        chk("cfg_in_reset", 9'h1ff, {pullup_disable, pin_edge_sel, tmr_a_src_sel,
            tmr_a_edge_sel, prescaler_owner_sel, 1'b1, prescale_rate});
        chk("ratios_in_reset", 9'h101, {wdt_ratio[0], tmr_a_ratio[7:0]});
        @(posedge clock);
        rst <= 1'b0;
        rd_reg(CSOIR_STATUS_OFF, 8'hff, 8'h18, "cpu_status");
        rd_reg(CSOIR_OPTION_OFF, 8'hff, 8'hff, "option_cfg");
        rd_reg(CSOIR_INTCTL_OFF, 8'hff, 8'h00, "irq_ctl");
        rd_reg(CSOIR_PMASK_OFF, 8'hff, 8'h00, "irq_mask");
        // software cannot touch the expiry and sleep bits; bank bits follow writes
        wr_reg(CSOIR_STATUS_OFF, 8'h00);
        rd_reg(CSOIR_STATUS_OFF, 8'hff, 8'h18, "cpu_status");
        wr_reg(CSOIR_STATUS_OFF, 8'he7);
        rd_reg(CSOIR_STATUS_OFF, 8'hff, 8'hff, "cpu_status");
        chk("banks", 9'h007, {6'h0, indirect_bank_hi, direct_bank_sel});
        wr_reg(CSOIR_STATUS_OFF, 8'h40);
        rd_reg(CSOIR_STATUS_OFF, 8'hff, 8'h58, "cpu_status");
        chk("banks", 9'h002, {6'h0, indirect_bank_hi, direct_bank_sel});
        // expiry, sleep and kick events on bits 4:3
        ev(0);
        rd_reg(CSOIR_STATUS_OFF, 8'h18, 8'h08, "expiry");
        ev(1);
        rd_reg(CSOIR_STATUS_OFF, 8'h18, 8'h10, "sleep");
        ev(2);
        rd_reg(CSOIR_STATUS_OFF, 8'h18, 8'h18, "kick");
        // flag-updating write keeps alu flags, upper data bits land
        alu(CSOIR_ALU_ARITH, 8'h00, 1'b1, 1'b0, 1'b1);
        rd_reg(CSOIR_STATUS_OFF, 8'hff, 8'h3d, "cpu_status");
        alu(CSOIR_ALU_ARITH, 8'h10, 1'b0, 1'b1, 1'b0);
        rd_reg(CSOIR_STATUS_OFF, 8'hff, 8'h3a, "cpu_status");
        alu(CSOIR_ALU_ROT, 8'h80, 1'b1, 1'b0, 1'b1);
        rd_reg(CSOIR_STATUS_OFF, 8'hff, 8'h3b, "cpu_status");
        wr_reg(CSOIR_STATUS_OFF, 8'he2);
        ev(4);
        rd_reg(CSOIR_STATUS_OFF, 8'hff, 8'h1e, "cpu_status");
        // every rate code under both prescaler owners
        for (int o = 0; o < 2; o++) begin
            for (int r = 0; r < 8; r++) begin
                v = {r[0], r[1], r[2], ~r[0], o[0], r[2:0]};
                wr_reg(CSOIR_OPTION_OFF, v);
                rd_reg(CSOIR_OPTION_OFF, 8'hff, v, "option_cfg");
                chk("option_outs", {1'b0, v}, {1'b0, pullup_disable, pin_edge_sel,
                    tmr_a_src_sel, tmr_a_edge_sel, prescaler_owner_sel,
                    prescale_rate});
                chk("tmr_a_ratio", o ? 9'd1 : 9'd2 << r, tmr_a_ratio);
                chk("wdt_ratio", o ? 9'd1 << r : 9'd1, {1'b0, wdt_ratio});
            end
        end
        // timer overflow flag sets with all enables off and sticks
        wr_reg(CSOIR_INTCTL_OFF, 8'h00);
        ev(3);
        rd_reg(CSOIR_INTCTL_OFF, 8'hff, 8'h04, "irq_ctl");
        chk("irq_req", 9'd0, 9'(irq_req));
        wr_reg(CSOIR_INTCTL_OFF, 8'ha4);
        repeat (3) @(negedge clock);
        chk("irq_req", 9'd1, 9'(irq_req));
        wr_reg(CSOIR_INTCTL_OFF, 8'h24);
        repeat (3) @(negedge clock);
        chk("irq_req", 9'd0, 9'(irq_req));
        wr_reg(CSOIR_INTCTL_OFF, 8'ha0);
        rd_reg(CSOIR_INTCTL_OFF, 8'hff, 8'ha0, "irq_ctl");
        chk("irq_req", 9'd0, 9'(irq_req));
        // falling edge selected: a rising edge must not set the pin flag
        wr_reg(CSOIR_INTCTL_OFF, 8'h00);
        // pins change at a rising edge; reads wait out the two-stage sync
        wr_reg(CSOIR_OPTION_OFF, 8'h00);
        ext_irq_pin <= 1'b1;
        repeat (2) @(posedge clock);
        rd_reg(CSOIR_INTCTL_OFF, 8'h02, 8'h00, "pin_flag");
        @(posedge clock);
        ext_irq_pin <= 1'b0;
        repeat (2) @(posedge clock);
        rd_reg(CSOIR_INTCTL_OFF, 8'h02, 8'h02, "pin_flag");
        wr_reg(CSOIR_INTCTL_OFF, 8'h90);
        wr_reg(CSOIR_OPTION_OFF, 8'h40);
        rd_reg(CSOIR_INTCTL_OFF, 8'hff, 8'h90, "irq_ctl");
        @(posedge clock);
        ext_irq_pin <= 1'b1;
        repeat (2) @(posedge clock);
        rd_reg(CSOIR_INTCTL_OFF, 8'hff, 8'h92, "irq_ctl");
        repeat (2) @(negedge clock);
        chk("irq_req", 9'd1, 9'(irq_req));
        // port change: mismatch keeps setting until the port is read
        wr_reg(CSOIR_INTCTL_OFF, 8'h00);
        port_b_pins <= 8'h30;
        repeat (2) @(posedge clock);
        rd_reg(CSOIR_INTCTL_OFF, 8'h01, 8'h01, "port_flag");
        wr_reg(CSOIR_INTCTL_OFF, 8'h00);
        rd_reg(CSOIR_INTCTL_OFF, 8'h01, 8'h01, "port_flag");
        rd_reg(CSOIR_PORT_B_PINS_OFF, 8'hf0, 8'h30, "port_b");
        wr_reg(CSOIR_INTCTL_OFF, 8'h00);
        rd_reg(CSOIR_INTCTL_OFF, 8'h01, 8'h00, "port_flag");
        // peripheral path: gate closed blocks, gate open passes, mask bit decides
        wr_reg(CSOIR_PMASK_OFF, 8'h08);
        wr_reg(CSOIR_INTCTL_OFF, 8'h80);
        @(posedge clock);
        periph_set <= 8'h08;
        @(posedge clock);
        periph_set <= 8'h00;
        rd_reg(CSOIR_PFLAG_OFF, 8'hff, 8'h08, "periph_flag");
        chk("irq_req", 9'd0, 9'(irq_req));
        wr_reg(CSOIR_INTCTL_OFF, 8'hc0);
        repeat (3) @(negedge clock);
        chk("irq_req", 9'd1, 9'(irq_req));
        wr_reg(CSOIR_PMASK_OFF, 8'ha5);
        rd_reg(CSOIR_PMASK_OFF, 8'hff, 8'ha5, "irq_mask");
        chk("irq_req", 9'd0, 9'(irq_req));
        wr_reg(CSOIR_PFLAG_OFF, 8'h00);
        rd_reg(CSOIR_PFLAG_OFF, 8'hff, 8'h00, "periph_flag");
        rd_reg(9'h1ff, 8'hff, 8'h00, "unmapped");
        // low enable: a write and an overflow must both be lost
        @(posedge clock);
        clk_en <= 1'b0;
        wr_reg(CSOIR_PMASK_OFF, 8'hff);
        ev(3);
        clk_en <= 1'b1;
        rd_reg(CSOIR_PMASK_OFF, 8'hff, 8'ha5, "frozen_mask");
        rd_reg(CSOIR_INTCTL_OFF, 8'hff, 8'hc0, "frozen_flags");
        print_verdict();
    end
endmodule
`default_nettype wire
